// [oled_cmd_decoder.sv]
`timescale 1ns/1ps
`default_nettype none

// Function
// - phase byte low nibble: phase one, reset 4
// - phase byte high nibble: phase two, reset 7
// - clock low nibble: divide by value plus one
// - clock high nibble: oscillator level, reset 6
// - second pre-charge period nibble, reset 8
// - gray command takes fifteen widths, levels 1-15
// - default table: width four times level
// - pre-charge level: five bits, reset 7
// - deselect level: three bits, reset 4
// - contrast: eight bits, reset 7fh
// - mux ratio 3 to 159, reset 159
// - protect byte: 12h unlocks, 16h locks
// - locked: ignore everything but protect command
// - column window loads, pointer to start
// - horizontal: column steps, wraps, row steps
// - row window loads, pointer to start
// - vertical: row steps, wraps to start
// - window end wraps both pointers
// - pointer advances after four pixels
// - write command then data bytes fill memory
// - read command then reads return memory
// - command byte dc low, parameters dc high
// - columns 0 to 79, window 0..79
// - rows 0 to 159, window 0..159
// - remap bit 0 picks increment direction

module oled_cmd_decoder (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic ram_we,
  output logic ram_re,
  output oled_pkg::ram_req_t ram_req,
  input wire logic [7:0] ram_rdata,
  output oled_pkg::timing_cfg_t timing,
  input wire logic [3:0] gray_level_sel,
  output logic [7:0] gray_width,
  output logic locked
);

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;
  logic addr_phase;
  logic [1:0] rd_wait;
  logic rd_pending;

  assign addr_phase = hsel && htrans[1] && hready;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_valid <= addr_phase;
      dp_write <= hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // byte stream decode

  oled_pkg::stream_t stream;
  oled_pkg::stream_t next_stream;
  logic [7:0] cur_cmd;
  logic [3:0] param_idx;
  logic [3:0] param_total;
  logic [7:0] wbyte;
  logic byte_valid;
  logic cmd_byte;
  logic cmd_taken;
  logic param_byte;
  logic data_byte;
  logic next_locked;
  logic read_open;
  logic [7:0] pend_start;

  assign wbyte = hwdata[7:0];
  assign byte_valid = dp_valid && dp_write &&
    (dp_addr == oled_pkg::REG_CMD || dp_addr == oled_pkg::REG_DATA);
  // command register carries dc low, data register dc high
  assign cmd_byte = byte_valid && dp_addr == oled_pkg::REG_CMD;
  assign cmd_taken = cmd_byte &&
    (!locked || wbyte == oled_pkg::CMD_PROTECT);
  assign param_byte = byte_valid && !cmd_byte &&
    stream == oled_pkg::S_PARAM;
  assign data_byte = byte_valid && !cmd_byte &&
    stream == oled_pkg::S_WRITE && !locked;

  function automatic logic [3:0] param_count(input logic [7:0] c);
    case (c)
      oled_pkg::CMD_COL_WIN,
      oled_pkg::CMD_ROW_WIN,
      oled_pkg::CMD_REMAP: param_count = oled_pkg::NPAR_TWO;
      oled_pkg::CMD_GRAY_TABLE: param_count = oled_pkg::NPAR_GRAY;
      oled_pkg::CMD_START_LINE,
      oled_pkg::CMD_OFFSET,
      oled_pkg::CMD_REF_CURRENT,
      oled_pkg::CMD_PHASE,
      oled_pkg::CMD_CLOCK,
      oled_pkg::CMD_PRECHARGE2,
      oled_pkg::CMD_PRECHARGE_CFG,
      oled_pkg::CMD_PRECHARGE_LVL,
      oled_pkg::CMD_DESELECT,
      oled_pkg::CMD_CONTRAST,
      oled_pkg::CMD_MUX,
      oled_pkg::CMD_PROTECT: param_count = oled_pkg::NPAR_ONE;
      default: param_count = 4'h0;
    endcase
  endfunction

  assign param_total = param_count(cur_cmd);

  always_comb begin
    next_stream = stream;
    if (cmd_taken) begin
      // any accepted command drops an unfinished one
      case (wbyte)
        oled_pkg::CMD_WRITE_RAM: next_stream = oled_pkg::S_WRITE;
        oled_pkg::CMD_READ_RAM: next_stream = oled_pkg::S_READ;
        default: begin
          if (param_count(wbyte) != 4'h0) begin
            next_stream = oled_pkg::S_PARAM;
          end else begin
            next_stream = oled_pkg::S_IDLE;
          end
        end
      endcase
    end else if (param_byte && param_idx == param_total - 4'h1) begin
      next_stream = oled_pkg::S_IDLE;
    end
  end

  always_comb begin
    next_locked = locked;
    if (param_byte && cur_cmd == oled_pkg::CMD_PROTECT) begin
      if (wbyte == oled_pkg::PROT_LOCK) begin
        next_locked = 1'b1;
      end else if (wbyte == oled_pkg::PROT_UNLOCK) begin
        next_locked = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stream <= oled_pkg::S_IDLE;
      locked <= 1'b0;
    end else begin
      stream <= next_stream;
      locked <= next_locked;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_cmd <= 8'h00;
      param_idx <= 4'h0;
    end else if (cmd_taken) begin
      cur_cmd <= wbyte;
      param_idx <= 4'h0;
    end else if (param_byte) begin
      param_idx <= param_idx + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // display timing settings

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timing.phase1 <= oled_pkg::PHASE1_RST;
      timing.phase2 <= oled_pkg::PHASE2_RST;
      timing.front_clock_divide <= oled_pkg::DIVIDE_RST;
      timing.osc_level <= oled_pkg::OSC_RST;
      timing.precharge2 <= oled_pkg::PRECHARGE2_RST;
      timing.precharge_level <= oled_pkg::PRECHARGE_LVL_RST;
      timing.com_deselect_voltage <= oled_pkg::DESELECT_RST;
      timing.segment_current <= oled_pkg::CONTRAST_RST;
      timing.mux_ratio <= oled_pkg::MUX_RST_FULL;
    end else if (param_byte) begin
      case (cur_cmd)
        oled_pkg::CMD_PHASE: begin
          // zero phases are illegal, keep the old length
          if (wbyte[3:0] != 4'h0) begin
            timing.phase1 <= wbyte[3:0];
          end
          if (wbyte[7:4] != 4'h0) begin
            timing.phase2 <= wbyte[7:4];
          end
        end
        oled_pkg::CMD_CLOCK: begin
          timing.front_clock_divide <= wbyte[3:0];
          timing.osc_level <= wbyte[7:4];
        end
        oled_pkg::CMD_PRECHARGE2: begin
          timing.precharge2 <= wbyte[3:0];
        end
        oled_pkg::CMD_PRECHARGE_LVL: begin
          timing.precharge_level <= wbyte[4:0];
        end
        oled_pkg::CMD_DESELECT: begin
          timing.com_deselect_voltage <= wbyte[2:0];
        end
        oled_pkg::CMD_CONTRAST: begin
          timing.segment_current <= wbyte;
        end
        oled_pkg::CMD_MUX: begin
          // 160 rows need the eighth bit, so the whole byte is kept
          if (wbyte >= oled_pkg::MUX_MIN && wbyte <= oled_pkg::MUX_MAX) begin
            timing.mux_ratio <= wbyte;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gray table

  logic gray_wr;
  logic gray_default;
  logic [7:0] gray_val;

  assign gray_wr = param_byte && cur_cmd == oled_pkg::CMD_GRAY_TABLE;
  assign gray_default = cmd_taken &&
    wbyte == oled_pkg::CMD_GRAY_DEFAULT;
  // widths beyond the documented ceiling are clipped
  assign gray_val = wbyte > oled_pkg::GRAY_MAX ?
    oled_pkg::GRAY_MAX : wbyte;

  gray_table u_gray (
    .clk(clk),
    .sys_rst(sys_rst),
    .load_default(gray_default),
    .wr_en(gray_wr),
    .wr_level(param_idx + 4'h1),
    .wr_data(gray_val),
    .rd_level(gray_level_sel),
    .rd_width(gray_width)
  );

  ////////////////////////////////////////////////////////////////////////
  // address windows and pointers

  logic vertical;
  logic col_load;
  logic row_load;
  logic step;
  logic [6:0] col_ptr;
  logic [7:0] row_ptr;
  logic [7:0] end_clamp_col;
  logic [7:0] end_clamp_row;

  // out-of-range end addresses fold onto the last legal one
  assign end_clamp_col = wbyte > {1'b0, oled_pkg::COL_END_RST} ?
    {1'b0, oled_pkg::COL_END_RST} : wbyte;
  assign end_clamp_row = wbyte > oled_pkg::ROW_END_RST ?
    oled_pkg::ROW_END_RST : wbyte;

  assign col_load = param_byte && cur_cmd == oled_pkg::CMD_COL_WIN &&
    param_idx == 4'h1;
  assign row_load = param_byte && cur_cmd == oled_pkg::CMD_ROW_WIN &&
    param_idx == 4'h1;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_start <= 8'h00;
    end else if (param_byte && param_idx == 4'h0) begin
      pend_start <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vertical <= 1'b0;
    end else if (param_byte && cur_cmd == oled_pkg::CMD_REMAP &&
                 param_idx == 4'h0) begin
      vertical <= wbyte[0];
    end
  end

  addr_pointer u_ptr (
    .clk(clk),
    .sys_rst(sys_rst),
    .col_load(col_load),
    .row_load(row_load),
    .win_start_col(pend_start[6:0]),
    .win_end_col(end_clamp_col[6:0]),
    .win_start_row(pend_start),
    .win_end_row(end_clamp_row),
    .vertical(vertical),
    .step(step),
    .col_ptr(col_ptr),
    .row_ptr(row_ptr)
  );

  ////////////////////////////////////////////////////////////////////////
  // display memory access

  // a read may follow the read command back to back
  assign read_open = next_stream == oled_pkg::S_READ && !next_locked;
  assign step = data_byte || (rd_pending && rd_wait == 2'h0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ram_we <= 1'b0;
      ram_re <= 1'b0;
      ram_req <= '0;
    end else begin
      ram_we <= data_byte;
      ram_re <= addr_phase && !hwrite &&
        haddr[7:0] == oled_pkg::REG_DATA && read_open;
      if (data_byte) begin
        ram_req <= {col_ptr, row_ptr, wbyte};
      end else if (addr_phase && !hwrite) begin
        ram_req <= {col_ptr, row_ptr, 8'h00};
      end
    end
  end

  // memory answers one cycle after ram_re; wait states cover it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_pending <= 1'b0;
      rd_wait <= 2'h0;
    end else if (addr_phase && !hwrite &&
                 haddr[7:0] == oled_pkg::REG_DATA && read_open) begin
      rd_pending <= 1'b1;
      rd_wait <= oled_pkg::RAM_RD_WAIT - 2'h1;
    end else if (rd_pending && rd_wait != 2'h0) begin
      rd_wait <= rd_wait - 2'h1;
    end else begin
      rd_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data and handshake

  logic [31:0] reg_rd;

  always_comb begin
    case (haddr[7:0])
      oled_pkg::REG_STATUS: reg_rd = {8'h00, cur_cmd, 4'h0,
        vertical, locked, stream, row_ptr[7:0] == 8'h00 ? 1'b0 : 1'b0,
        col_ptr};
      oled_pkg::REG_TIMING: reg_rd = {timing.phase1, timing.phase2,
        timing.front_clock_divide, timing.osc_level,
        timing.precharge2, 4'h0, timing.segment_current};
      oled_pkg::REG_LEVELS: reg_rd = {8'h00, row_ptr,
        timing.mux_ratio, timing.com_deselect_voltage,
        timing.precharge_level};
      default: reg_rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pending && rd_wait == 2'h0) begin
      hrdata <= {24'h00_0000, ram_rdata};
    end else if (addr_phase && !hwrite) begin
      hrdata <= reg_rd;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (addr_phase && !hwrite &&
          haddr[7:0] == oled_pkg::REG_DATA && read_open) begin
        hreadyout <= 1'b0;
      end else if (rd_pending && rd_wait == 2'h0) begin
        hreadyout <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [oled_pkg.sv]
package oled_pkg;

  // command codes
  localparam logic [7:0] CMD_COL_WIN = 8'h15;
  localparam logic [7:0] CMD_ROW_WIN = 8'h75;
  localparam logic [7:0] CMD_WRITE_RAM = 8'h5c;
  localparam logic [7:0] CMD_READ_RAM = 8'h5d;
  localparam logic [7:0] CMD_REMAP = 8'ha0;
  localparam logic [7:0] CMD_START_LINE = 8'ha1;
  localparam logic [7:0] CMD_OFFSET = 8'ha2;
  localparam logic [7:0] CMD_REF_CURRENT = 8'had;
  localparam logic [7:0] CMD_PHASE = 8'hb1;
  localparam logic [7:0] CMD_CLOCK = 8'hb3;
  localparam logic [7:0] CMD_PRECHARGE2 = 8'hb6;
  localparam logic [7:0] CMD_GRAY_TABLE = 8'hb8;
  localparam logic [7:0] CMD_GRAY_DEFAULT = 8'hb9;
  localparam logic [7:0] CMD_PRECHARGE_CFG = 8'hba;
  localparam logic [7:0] CMD_PRECHARGE_LVL = 8'hbb;
  localparam logic [7:0] CMD_DESELECT = 8'hbe;
  localparam logic [7:0] CMD_CONTRAST = 8'hc1;
  localparam logic [7:0] CMD_MUX = 8'hca;
  localparam logic [7:0] CMD_PROTECT = 8'hfd;
  localparam logic [7:0] PROT_UNLOCK = 8'h12;
  localparam logic [7:0] PROT_LOCK = 8'h16;

  // parameter byte counts
  localparam logic [3:0] NPAR_ONE = 4'h1;
  localparam logic [3:0] NPAR_TWO = 4'h2;
  localparam logic [3:0] NPAR_GRAY = 4'hf;

  // reset values
  localparam logic [3:0] PHASE1_RST = 4'h4;
  localparam logic [3:0] PHASE2_RST = 4'h7;
  localparam logic [3:0] DIVIDE_RST = 4'h0;
  localparam logic [3:0] OSC_RST = 4'h6;
  localparam logic [3:0] PRECHARGE2_RST = 4'h8;
  localparam logic [4:0] PRECHARGE_LVL_RST = 5'h07;
  localparam logic [2:0] DESELECT_RST = 3'h4;
  localparam logic [7:0] CONTRAST_RST = 8'h7f;
  localparam logic [6:0] MUX_RST = 7'h1f + 7'h00;
  localparam logic [7:0] MUX_RST_FULL = 8'h9f;
  localparam logic [7:0] MUX_MIN = 8'h03;
  localparam logic [7:0] MUX_MAX = 8'h9f;
  localparam logic [7:0] GRAY_MAX = 8'hb4;
  localparam logic [7:0] GRAY_STEP = 8'h04;

  // address space of display memory
  localparam int COL_W = 7;
  localparam int ROW_W = 8;
  localparam logic [6:0] COL_START_RST = 7'h00;
  localparam logic [6:0] COL_END_RST = 7'h4f;
  localparam logic [7:0] ROW_START_RST = 8'h00;
  localparam logic [7:0] ROW_END_RST = 8'h9f;
  // two 4-bit pixels per byte, four pixels per column
  localparam logic [0:0] BYTES_PER_COL_M1 = 1'h1;

  // bus register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_TIMING = 8'h0c;
  localparam logic [7:0] REG_LEVELS = 8'h10;
  localparam logic [1:0] RAM_RD_WAIT = 2'h2;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PARAM = 2'b01,
    S_WRITE = 2'b10,
    S_READ = 2'b11
  } stream_t;

  typedef struct packed {
    logic [3:0] phase1;
    logic [3:0] phase2;
    logic [3:0] front_clock_divide;
    logic [3:0] osc_level;
    logic [3:0] precharge2;
    logic [4:0] precharge_level;
    logic [2:0] com_deselect_voltage;
    logic [7:0] segment_current;
    logic [7:0] mux_ratio;
  } timing_cfg_t;

  typedef struct packed {
    logic [6:0] col;
    logic [7:0] row;
    logic [7:0] wdata;
  } ram_req_t;

endpackage

// [gray_table.sv]
`timescale 1ns/1ps
`default_nettype none

module gray_table (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load_default,
  input wire logic wr_en,
  input wire logic [3:0] wr_level,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] rd_level,
  output logic [7:0] rd_width
);

  wire logic [15:0][7:0] width;

  assign width[0] = 8'h00;

  genvar g;
  generate
    for (g = 1; g < 16; g++) begin : g_level
      logic [7:0] w;
      always_ff @(posedge clk) begin
        if (sys_rst || load_default) begin
          w <= 8'(g) * oled_pkg::GRAY_STEP;
        end else if (wr_en && wr_level == 4'(g)) begin
          w <= wr_data;
        end
      end
      assign width[g] = w;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_width <= 8'h00;
    end else begin
      rd_width <= width[rd_level];
    end
  end

endmodule

`default_nettype wire

// [addr_pointer.sv]
`timescale 1ns/1ps
`default_nettype none

module addr_pointer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic col_load,
  input wire logic row_load,
  input wire logic [6:0] win_start_col,
  input wire logic [6:0] win_end_col,
  input wire logic [7:0] win_start_row,
  input wire logic [7:0] win_end_row,
  input wire logic vertical,
  input wire logic step,
  output logic [6:0] col_ptr,
  output logic [7:0] row_ptr
);

  logic [6:0] col_start;
  logic [6:0] col_end;
  logic [7:0] row_start;
  logic [7:0] row_end;
  logic byte_half;
  logic col_last;
  logic row_last;
  logic advance;

  assign col_last = col_ptr == col_end;
  assign row_last = row_ptr == row_end;
  assign advance = step && byte_half == oled_pkg::BYTES_PER_COL_M1;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      col_start <= oled_pkg::COL_START_RST;
      col_end <= oled_pkg::COL_END_RST;
      row_start <= oled_pkg::ROW_START_RST;
      row_end <= oled_pkg::ROW_END_RST;
    end else begin
      if (col_load) begin
        col_start <= win_start_col;
        col_end <= win_end_col;
      end
      if (row_load) begin
        row_start <= win_start_row;
        row_end <= win_end_row;
      end
    end
  end

  // partial column restarts when the window changes
  always_ff @(posedge clk) begin
    if (sys_rst || col_load || row_load) begin
      byte_half <= 1'b0;
    end else if (step) begin
      byte_half <= ~byte_half;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      col_ptr <= oled_pkg::COL_START_RST;
      row_ptr <= oled_pkg::ROW_START_RST;
    end else begin
      if (col_load) begin
        col_ptr <= win_start_col;
      end else if (advance && !vertical) begin
        col_ptr <= col_last ? col_start : col_ptr + 7'h01;
      end else if (advance && row_last) begin
        col_ptr <= col_last ? col_start : col_ptr + 7'h01;
      end
      if (row_load) begin
        row_ptr <= win_start_row;
      end else if (advance && vertical) begin
        row_ptr <= row_last ? row_start : row_ptr + 8'h01;
      end else if (advance && col_last) begin
        row_ptr <= row_last ? row_start : row_ptr + 8'h01;
      end
    end
  end

endmodule

`default_nettype wire

// [oled_cmd_decoder_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module oled_cmd_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hreadyout,
  input wire logic ram_we,
  input wire logic ram_re,
  input wire oled_pkg::ram_req_t ram_req,
  input wire oled_pkg::timing_cfg_t timing,
  input wire logic [7:0] gray_width,
  input wire logic locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // memory read holds the bus for exactly two cycles
  sequence s_rd_wait;
    !hreadyout ##1 !hreadyout ##1 hreadyout;
  endsequence

  a_rst_timing: assert property (disable iff (1'b0)
    sys_rst |=> timing == {4'h4, 4'h7, 4'h0, 4'h6, 4'h8, 5'h07, 3'h4,
      8'h7f, 8'h9f}) else $error("timing not at defaults after reset");
  a_phase_valid: assert property (timing.phase1 != 0 &&
    timing.phase2 != 0) else $error("zero phase length stored");
  a_mux_range: assert property (
    timing.mux_ratio inside {[8'h03:8'h9f]}) else $error("mux out of range");
  a_gray_limit: assert property (gray_width <= 8'hb4)
    else $error("gray width above limit");
  a_lock_quiet: assert property (locked |-> !ram_we && !ram_re)
    else $error("memory access while locked");
  a_lock_hold: assert property (
    locked && $past(locked) |-> $stable(timing))
    else $error("setting changed while locked");
  a_addr_range: assert property ((ram_we || ram_re) |->
    ram_req.col <= 7'h4f && ram_req.row <= 8'h9f)
    else $error("pointer outside memory");
  a_read_wait: assert property ($rose(ram_re) |-> s_rd_wait)
    else $error("read wait not two cycles");
  a_re_pulse: assert property (ram_re |=> !ram_re)
    else $error("read strobe longer than one cycle");
  a_stall_cause: assert property (
    !hreadyout |-> ram_re || $past(ram_re))
    else $error("stall without memory read");
endmodule

bind oled_cmd_decoder oled_cmd_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .hreadyout(hreadyout), .ram_we(ram_we), .ram_re(ram_re),
  .ram_req(ram_req), .timing(timing), .gray_width(gray_width),
  .locked(locked));

`default_nettype wire

// [ram_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ram_model (
  input wire logic clk,
  input wire logic ram_we,
  input wire logic ram_re,
  input wire oled_pkg::ram_req_t ram_req,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [0:32767];

  initial ram_rdata = 8'h00;

  always @(posedge clk) begin
    if (ram_we) begin
      mem[{ram_req.col, ram_req.row}] <= ram_req.wdata;
    end
    if (ram_re) begin
      ram_rdata <= mem[{ram_req.col, ram_req.row}];
    end else begin
      // no hold after the read slot: a late sample sees junk
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule

`default_nettype wire

// [oled_command_decoder_ram_pointer_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module oled_command_decoder_ram_pointer_tb;
  logic clk = 0;
  logic sys_rst = 1;
  logic hsel = 0;
  logic hwrite = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] gray_level_sel = 0;
  logic [31:0] hrdata, r;
  logic hreadyout, hresp, ram_we, ram_re, locked;
  logic [7:0] ram_rdata, gray_width, cv;
  logic [7:0] d [0:9];
  oled_pkg::ram_req_t ram_req;
  oled_pkg::ram_req_t exp_q[$];
  oled_pkg::timing_cfg_t timing;
  int err_count = 0;
  int n_checks = 0;
  int i, k;

  always #5 clk = ~clk;

  oled_cmd_decoder u_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ram_we(ram_we),
    .ram_re(ram_re), .ram_req(ram_req), .ram_rdata(ram_rdata),
    .timing(timing), .gray_level_sel(gray_level_sel),
    .gray_width(gray_width), .locked(locked));

  ram_model u_ram (.clk(clk), .ram_we(ram_we), .ram_re(ram_re),
    .ram_req(ram_req), .ram_rdata(ram_rdata));

  //////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // ready is looked at mid-cycle, where the registered value has settled
  task automatic wt();
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    r = hrdata;
    if (n >= 40) begin
      err_count++;
      finish_test();
    end
    @(posedge clk);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt();
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= {24'h0, v};
    wt();
  endtask

  task automatic cmd(input logic [7:0] c);
    xfer(1, 8'h00, c);
  endtask

  task automatic dat(input logic [7:0] v);
    xfer(1, 8'h04, v);
  endtask

  task automatic pc(input logic [7:0] c, input logic [7:0] v);
    cmd(c);
    dat(v);
  endtask

  task automatic rdr(input logic [7:0] a);
    xfer(0, a, 8'h00);
  endtask

  task automatic gw(input logic [3:0] n, input logic [7:0] e);
    gray_level_sel <= n;
    @(posedge clk);
    @(negedge clk);
    chk(gray_width, e);
    @(posedge clk);
  endtask

  task automatic win();
    pc(8'h15, 8'h02);
    dat(8'h03);
    pc(8'h75, 8'h05);
    dat(8'h06);
  endtask

  // 2x2 window at col 2..3, row 5..6; one address per two bytes
  function automatic oled_pkg::ram_req_t at(input int j, input logic v,
      input logic [7:0] w);
    int q;
    q = (j / 2) % 4;
    at.wdata = w;
    at.col = v ? 7'(2 + q / 2) : 7'(2 + q % 2);
    at.row = v ? 8'(5 + q % 2) : 8'(5 + q / 2);
  endfunction

  always @(negedge clk) begin
    if (ram_we === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk(ram_req, exp_q.pop_front());
    end
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    i = $urandom(55584);
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    rdr(8'h0c);
    chk(r, 32'h4706807f);
    rdr(8'h10);
    chk(r, 32'h00009f87);
    cv = 8'($urandom);
    pc(8'hb1, 8'h3c);
    pc(8'hb1, 8'h00);
    pc(8'hb3, 8'ha5);
    pc(8'hb6, 8'h0f);
    pc(8'hc1, cv);
    pc(8'hbb, 8'h1f);
    pc(8'hbe, 8'h07);
    pc(8'hca, 8'h03);
    rdr(8'h0c);
    chk(r, {16'hc35a, 8'hf0, cv});
    rdr(8'h10);
    chk(r, 32'h000003ff);
    cmd(8'hc1);
    pc(8'hca, 8'h20);
    rdr(8'h10);
    chk(r, 32'h000020ff);
    chk(timing.mux_ratio, 8'h20);
    chk(hresp, 1'b0);
    rdr(8'h0c);
    chk(r[7:0], cv);
    cmd(8'hb8);
    // top level sent above the ceiling: must come back clipped to 180
    for (i = 1; i < 16; i++) dat(i == 15 ? 8'hff : 8'(12 * i));
    for (i = 1; i < 16; i++) gw(i[3:0], 8'(12 * i));
    cmd(8'hb9);
    for (i = 0; i < 16; i++) gw(i[3:0], 8'(4 * i));
    for (k = 0; k < 2; k++) begin
      if (k == 1) begin
        pc(8'ha0, 8'h01);
        dat(8'h00);
      end
      win();
      cmd(8'h5c);
      for (i = 0; i < 10; i++) begin
        d[i] = 8'($urandom);
        exp_q.push_back(at(i, k[0], d[i]));
        dat(d[i]);
      end
    end
    win();
    cmd(8'h5d);
    for (i = 0; i < 8; i++) begin
      rdr(8'h04);
      chk(r[7:0], d[(i < 2) ? 9 : (i / 2) * 2 + 1]);
    end
    pc(8'hfd, 8'h16);
    rdr(8'h08);
    chk(r[10], 1'b1);
    chk(locked, 1'b1);
    pc(8'hc1, ~cv);
    pc(8'h5c, 8'h55);
    rdr(8'h0c);
    chk(r[7:0], cv);
    pc(8'hfd, 8'h12);
    rdr(8'h08);
    chk(r[10], 1'b0);
    pc(8'hc1, ~cv);
    rdr(8'h0c);
    chk(r[7:0], {24'h0, ~cv});
    chk(32'(exp_q.size()), 32'h0);
    sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    rdr(8'h0c);
    chk(r, 32'h4706807f);
    finish_test();
  end
endmodule

`default_nettype wire
